/* shared/cec_cfg.svh */
// cec_cfg.svh: timing, size and reset constants of the cec engine
// assumes a 100 MHz core clock and a 32.768 kHz sampling time base
`ifndef CEC_CFG_SVH
`define CEC_CFG_SVH
`define CLK_PERIOD_NS 10
`define FS_TICK_NS 30518
`define TICK_CYC (`FS_TICK_NS / `CLK_PERIOD_NS)
`define US2TK_UP(us) ((((us) * 1000) + `FS_TICK_NS - 1) / `FS_TICK_NS)
`define US2TK_DN(us) (((us) * 1000) / `FS_TICK_NS)
`define ACK_LOW_US 1526
`define ACK_CHK_US 300
`define ACK_WIN_US 2000
`define MIN_LOW_US 3630
`define BIT_US 2400
`define START_LOW_US 3700
`define START_PRD_US 4500
`define START_DET_US 3500
`define D0_LOW_US 1500
`define D1_LOW_US 600
`define SAMPLE_US 1050
`define WAV_E1_US 400
`define WAV_L1_US 800
`define WAV_E0_US 1300
`define WAV_L0_US 1700
`define MIN_CYC_TK 67
`define MAX_CYC_TK 90
`define FIFO_DEPTH 32
`define TX_WORD_W 9
`define FLAG_RST 1'b0
`endif

/* shared/cec_pkg.sv */
// cec_pkg: types shared by the cec engine
// assumes cec_cfg.svh supplies all numeric constants
package cec_pkg;
  typedef logic [7:0] tk_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_SBIT = 3'b001,
    RX_BITS = 3'b011,
    RX_ACK = 3'b010,
    RX_ERRLOW = 3'b110
  } rx_state_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_ACK = 2'b10
  } tx_state_e;
endpackage : cec_pkg

/* core/cec_engine.sv */
// cec_engine: single-wire cec receive error handling and byte transmitter
// assumes an open-drain line resolved outside, software flags as plain ports
`timescale 1ns/100ps
`include "cec_cfg.svh"

module cec_tx_fifo #(
  parameter int W = `TX_WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // ready from a flop so the source sees honest back-pressure
      in_ready <= (cnt_d != (AW + 1)'(DEPTH));
    end
  end
endmodule : cec_tx_fifo

module cec_engine import cec_pkg::*; #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  input wire logic peripheral_enable,
  input wire logic soft_reset_bit,
  input wire logic receive_enable_bit,
  input wire logic error_suspend_select,
  input wire logic [3:0] suspend_timeout_value,
  input wire logic waveform_check_enable,
  input wire logic ack_respond,
  input wire logic rx_read,
  output logic [7:0] rx_data,
  output logic rx_eom,
  output logic rx_data_valid,
  input wire logic rx_status_clear,
  output logic rx_complete_flag,
  output logic ack_collision_flag,
  output logic min_cycle_error_flag,
  output logic max_cycle_error_flag,
  output logic rx_overrun_flag,
  output logic waveform_error_flag,
  output logic rx_irq,
  input wire logic tx_enable_set,
  output logic transmit_enable_bit,
  input wire logic broadcast_select,
  input wire logic [3:0] bus_idle_wait_count,
  input wire logic [1:0] start_rise_adjust,
  input wire logic [1:0] start_period_adjust,
  input wire logic [1:0] data_rise_adjust,
  input wire logic [1:0] data_period_adjust,
  input wire logic tx_valid,
  input wire logic [8:0] tx_data,
  output logic tx_ready,
  input wire logic tx_status_clear,
  output logic tx_start_flag,
  output logic tx_end_flag,
  output logic arbitration_lost_flag,
  output logic tx_ack_error_flag,
  output logic tx_underrun_flag,
  output logic tx_irq
);
  localparam tk_t ACK_LOW = tk_t'(`US2TK_UP(`ACK_LOW_US));
  localparam tk_t ACK_CHK = tk_t'(`US2TK_UP(`ACK_LOW_US + `ACK_CHK_US));
  localparam tk_t ACK_WIN = tk_t'(`US2TK_DN(`ACK_WIN_US));
  localparam tk_t MIN_LOW = tk_t'(`US2TK_UP(`MIN_LOW_US));
  localparam tk_t BIT_TK = tk_t'(`US2TK_UP(`BIT_US));
  localparam tk_t ST_LOW = tk_t'(`US2TK_UP(`START_LOW_US));
  localparam tk_t ST_PRD = tk_t'(`US2TK_UP(`START_PRD_US));
  localparam tk_t ST_DET = tk_t'(`US2TK_UP(`START_DET_US));
  localparam tk_t D0_LOW = tk_t'(`US2TK_UP(`D0_LOW_US));
  localparam tk_t D1_LOW = tk_t'(`US2TK_UP(`D1_LOW_US));
  localparam tk_t SAMPLE = tk_t'(`US2TK_UP(`SAMPLE_US));
  localparam tk_t WAV_E1 = tk_t'(`US2TK_UP(`WAV_E1_US));
  localparam tk_t WAV_L1 = tk_t'(`US2TK_DN(`WAV_L1_US));
  localparam tk_t WAV_E0 = tk_t'(`US2TK_UP(`WAV_E0_US));
  localparam tk_t WAV_L0 = tk_t'(`US2TK_DN(`WAV_L0_US));
  localparam tk_t MIN_CYC = tk_t'(`MIN_CYC_TK);
  localparam tk_t MAX_CYC = tk_t'(`MAX_CYC_TK);

  function automatic tk_t tk_inc(input tk_t v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : tk_inc

  function automatic logic wav_bad(input tk_t low);
    return (low < WAV_E1) || ((low > WAV_L1) && (low < WAV_E0)) || (low > WAV_L0);
  endfunction : wav_bad

  logic [2:0] sync_q;
  logic line_q;
  logic line_old_q;
  logic fall;
  logic rise;
  logic [11:0] tdiv_q;
  logic tick_q;
  tk_t idle_tk_q;
  logic [4:0] idle_bits_q;
  logic bus_free;
  rx_state_e rx_st_q;
  tk_t rx_tk_q;
  tk_t elow_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_drv_q;
  logic drove_q;
  logic hold_q;
  logic maxseen_q;
  logic pend_max_q;
  logic pend_wav_q;
  logic pend_or_q;
  logic rx_run;
  logic susp_on;
  logic ev_min;
  logic ev_max;
  logic ev_wav;
  logic ev_col;
  logic ev_done;
  logic ev_tout;
  logic ovr;
  tx_state_e tx_st_q;
  tk_t tx_tk_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_eom_q;
  logic tx_resp_q;
  logic tx_drv_q;
  logic tx_ack_pend_q;
  tk_t tx_low;
  tk_t tx_prd;
  logic tx_eob;
  logic tx_ackerr;
  logic tx_load;
  logic fifo_valid;
  logic [8:0] fifo_data;

  cec_tx_fifo #(.W(`TX_WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clr(soft_reset_bit),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(tx_load)
  );

  // line filter: 2nd and 3rd stage must agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
      line_old_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], line_in};
      if (sync_q[1] == sync_q[2]) begin
        line_q <= sync_q[2];
      end
      line_old_q <= line_q;
    end
  end

  assign fall = line_old_q && !line_q;
  assign rise = !line_old_q && line_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdiv_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tdiv_q == 12'(TICK_CYC - 1));
      tdiv_q <= (tdiv_q == 12'(TICK_CYC - 1)) ? 12'h000 : tdiv_q + 12'h001;
    end
  end

  // bus idle tracking runs regardless of transmit state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_tk_q <= 8'h00;
      idle_bits_q <= 5'h00;
    end else if (fall || soft_reset_bit) begin
      idle_tk_q <= 8'h00;
      idle_bits_q <= 5'h00;
    end else if (tick_q && line_q) begin
      if (tk_inc(idle_tk_q) == BIT_TK) begin
        idle_tk_q <= 8'h00;
        idle_bits_q <= (idle_bits_q == 5'h1f) ? idle_bits_q : idle_bits_q + 5'h01;
      end else begin
        idle_tk_q <= tk_inc(idle_tk_q);
      end
    end
  end

  assign bus_free = idle_bits_q >= 5'(bus_idle_wait_count) + 5'h02;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_tk_q <= 8'h00;
    end else if (fall) begin
      rx_tk_q <= 8'h00;
    end else if (tick_q) begin
      rx_tk_q <= tk_inc(rx_tk_q);
    end
  end

  assign rx_run = receive_enable_bit && peripheral_enable && (tx_st_q == TX_IDLE);
  assign susp_on = error_suspend_select && (suspend_timeout_value != 4'h0);
  assign ovr = rx_data_valid && !rx_read;

  always_comb begin
    ev_min = 1'b0;
    ev_max = 1'b0;
    ev_wav = 1'b0;
    ev_col = 1'b0;
    ev_done = 1'b0;
    ev_tout = 1'b0;
    if (rx_st_q == RX_BITS) begin
      ev_min = fall && (rx_bit_q != 4'h0) && (rx_tk_q < MIN_CYC);
      ev_wav = rise && waveform_check_enable && wav_bad(rx_tk_q);
      ev_max = tick_q && !fall && !maxseen_q && (tk_inc(rx_tk_q) == MAX_CYC);
      ev_tout = hold_q && (idle_bits_q >= 5'(suspend_timeout_value) + 5'h01);
    end
    if (rx_st_q == RX_ACK && tick_q) begin
      ev_col = drove_q && (rx_tk_q == ACK_CHK) && !line_q;
      ev_min = drove_q && (rx_tk_q > ACK_CHK) && !line_q;
      ev_done = !ev_col && !ev_min && (tk_inc(rx_tk_q) == ACK_WIN);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_drv_q <= 1'b0;
      drove_q <= 1'b0;
      elow_q <= 8'h00;
      hold_q <= 1'b0;
      maxseen_q <= 1'b0;
      pend_max_q <= 1'b0;
      pend_wav_q <= 1'b0;
      pend_or_q <= 1'b0;
      rx_data <= 8'h00;
      rx_eom <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_complete_flag <= `FLAG_RST;
      ack_collision_flag <= `FLAG_RST;
      min_cycle_error_flag <= `FLAG_RST;
      max_cycle_error_flag <= `FLAG_RST;
      rx_overrun_flag <= `FLAG_RST;
      waveform_error_flag <= `FLAG_RST;
      rx_irq <= 1'b0;
    end else if (soft_reset_bit) begin
      rx_st_q <= RX_IDLE;
      rx_drv_q <= 1'b0;
      drove_q <= 1'b0;
      hold_q <= 1'b0;
      pend_max_q <= 1'b0;
      pend_wav_q <= 1'b0;
      pend_or_q <= 1'b0;
      rx_data <= 8'h00;
      rx_eom <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_complete_flag <= `FLAG_RST;
      ack_collision_flag <= `FLAG_RST;
      min_cycle_error_flag <= `FLAG_RST;
      max_cycle_error_flag <= `FLAG_RST;
      rx_overrun_flag <= `FLAG_RST;
      waveform_error_flag <= `FLAG_RST;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      if (rx_read) begin
        rx_data_valid <= 1'b0;
      end
      if (rx_status_clear) begin
        rx_complete_flag <= 1'b0;
        ack_collision_flag <= 1'b0;
        min_cycle_error_flag <= 1'b0;
        max_cycle_error_flag <= 1'b0;
        rx_overrun_flag <= 1'b0;
        waveform_error_flag <= 1'b0;
      end
      if (!rx_run) begin
        rx_st_q <= RX_IDLE;
        rx_drv_q <= 1'b0;
        hold_q <= 1'b0;
        pend_max_q <= 1'b0;
        pend_wav_q <= 1'b0;
        pend_or_q <= 1'b0;
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            if (fall) begin
              rx_st_q <= RX_SBIT;
            end
          end
          RX_SBIT: begin
            if (rise) begin
              rx_st_q <= (rx_tk_q >= ST_DET) ? RX_BITS : RX_IDLE;
              rx_bit_q <= 4'h0;
              maxseen_q <= 1'b1;
            end
          end
          RX_BITS: begin
            if (fall) begin
              maxseen_q <= 1'b0;
            end
            if (rise) begin
              rx_sh_q <= {rx_sh_q[7:0], (rx_tk_q < SAMPLE)};
              rx_bit_q <= rx_bit_q + 4'h1;
            end
            if (fall && rx_bit_q == 4'h9) begin
              rx_st_q <= RX_ACK;
              rx_drv_q <= ack_respond && !hold_q;
              drove_q <= ack_respond && !hold_q;
            end
            if (ev_max || ev_wav) begin
              maxseen_q <= maxseen_q || ev_max;
              if (susp_on) begin
                hold_q <= 1'b1;
                pend_max_q <= pend_max_q || ev_max;
                pend_wav_q <= pend_wav_q || ev_wav;
              end else begin
                max_cycle_error_flag <= max_cycle_error_flag || ev_max;
                waveform_error_flag <= waveform_error_flag || ev_wav;
                rx_irq <= 1'b1;
                rx_st_q <= RX_IDLE;
              end
            end
            if (ev_tout) begin
              max_cycle_error_flag <= max_cycle_error_flag || pend_max_q;
              waveform_error_flag <= waveform_error_flag || pend_wav_q;
              rx_overrun_flag <= rx_overrun_flag || pend_or_q;
              rx_irq <= 1'b1;
              rx_st_q <= RX_IDLE;
              hold_q <= 1'b0;
              pend_max_q <= 1'b0;
              pend_wav_q <= 1'b0;
              pend_or_q <= 1'b0;
            end
          end
          RX_ACK: begin
            if (tick_q && tk_inc(rx_tk_q) == ACK_LOW) begin
              rx_drv_q <= 1'b0;
            end
            if (ev_col) begin
              ack_collision_flag <= 1'b1;
              rx_irq <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
            if (ev_done) begin
              if (!ovr) begin
                rx_data <= rx_sh_q[8:1];
                rx_eom <= rx_sh_q[0];
                rx_data_valid <= 1'b1;
              end
              if (ovr && !susp_on && !hold_q) begin
                rx_overrun_flag <= 1'b1;
                rx_st_q <= RX_IDLE;
              end else begin
                rx_complete_flag <= 1'b1;
                max_cycle_error_flag <= max_cycle_error_flag || pend_max_q;
                waveform_error_flag <= waveform_error_flag || pend_wav_q;
                rx_overrun_flag <= rx_overrun_flag || pend_or_q || ovr;
                pend_max_q <= 1'b0;
                pend_wav_q <= 1'b0;
                pend_or_q <= 1'b0;
                rx_st_q <= rx_sh_q[0] ? RX_IDLE : RX_BITS;
                hold_q <= hold_q && !rx_sh_q[0];
                rx_bit_q <= 4'h0;
                maxseen_q <= 1'b0;
              end
              rx_irq <= 1'b1;
            end
          end
          RX_ERRLOW: begin
            if (tick_q) begin
              elow_q <= tk_inc(elow_q);
            end
            if (tick_q && tk_inc(elow_q) == MIN_LOW) begin
              rx_drv_q <= 1'b0;
              rx_st_q <= RX_IDLE;
            end
          end
          default: begin
            rx_st_q <= RX_IDLE;
          end
        endcase
        if (ev_min) begin
          min_cycle_error_flag <= 1'b1;
          max_cycle_error_flag <= max_cycle_error_flag || pend_max_q;
          waveform_error_flag <= waveform_error_flag || pend_wav_q;
          rx_overrun_flag <= rx_overrun_flag || pend_or_q;
          pend_max_q <= 1'b0;
          pend_wav_q <= 1'b0;
          pend_or_q <= 1'b0;
          hold_q <= 1'b0;
          rx_irq <= 1'b1;
          rx_st_q <= RX_ERRLOW;
          rx_drv_q <= 1'b1;
          elow_q <= 8'h00;
        end
      end
    end
  end

  always_comb begin
    if (tx_st_q == TX_START) begin
      tx_low = ST_LOW - tk_t'(start_rise_adjust);
      tx_prd = ST_PRD - tk_t'(start_period_adjust);
    end else begin
      tx_low = ((tx_st_q == TX_ACK) || tx_sh_q[8]) ? D1_LOW : D0_LOW;
      tx_low = tx_low - tk_t'(data_rise_adjust);
      tx_prd = BIT_TK - tk_t'(data_period_adjust);
    end
  end

  assign tx_eob = tick_q && (tk_inc(tx_tk_q) == tx_prd);
  assign tx_ackerr = broadcast_select ? !tx_resp_q : tx_resp_q;
  assign tx_load = tx_eob && ((tx_st_q == TX_START) ||
                   ((tx_st_q == TX_ACK) && !tx_eom_q && fifo_valid && !tx_ackerr));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_tk_q <= 8'h00;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_eom_q <= 1'b0;
      tx_resp_q <= 1'b1;
      tx_drv_q <= 1'b0;
      tx_ack_pend_q <= 1'b0;
      transmit_enable_bit <= 1'b0;
      tx_start_flag <= `FLAG_RST;
      tx_end_flag <= `FLAG_RST;
      arbitration_lost_flag <= `FLAG_RST;
      tx_ack_error_flag <= `FLAG_RST;
      tx_underrun_flag <= `FLAG_RST;
      tx_irq <= 1'b0;
    end else if (soft_reset_bit) begin
      tx_st_q <= TX_IDLE;
      tx_drv_q <= 1'b0;
      tx_ack_pend_q <= 1'b0;
      transmit_enable_bit <= 1'b0;
      tx_start_flag <= `FLAG_RST;
      tx_end_flag <= `FLAG_RST;
      arbitration_lost_flag <= `FLAG_RST;
      tx_ack_error_flag <= `FLAG_RST;
      tx_underrun_flag <= `FLAG_RST;
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= 1'b0;
      if (tx_enable_set) begin
        transmit_enable_bit <= 1'b1;
      end
      if (tx_status_clear) begin
        tx_start_flag <= 1'b0;
        tx_end_flag <= 1'b0;
        arbitration_lost_flag <= 1'b0;
        tx_ack_error_flag <= 1'b0;
        tx_underrun_flag <= 1'b0;
      end
      if (tx_ack_pend_q) begin
        tx_ack_error_flag <= 1'b1;
        tx_irq <= 1'b1;
        tx_ack_pend_q <= 1'b0;
      end
      if (tx_st_q != TX_IDLE && tick_q) begin
        tx_tk_q <= tk_inc(tx_tk_q);
        if (tk_inc(tx_tk_q) == tx_low) begin
          tx_drv_q <= 1'b0;
        end
        if (tx_st_q == TX_ACK && tx_tk_q == SAMPLE) begin
          tx_resp_q <= line_q;
        end
      end
      case (tx_st_q)
        TX_IDLE: begin
          if (transmit_enable_bit && peripheral_enable && bus_free && fifo_valid) begin
            tx_st_q <= TX_START;
            tx_tk_q <= 8'h00;
            tx_drv_q <= 1'b1;
          end
        end
        TX_START, TX_DATA: begin
          if (tick_q && tx_tk_q == tx_low && !line_q) begin
            arbitration_lost_flag <= 1'b1;
            tx_irq <= 1'b1;
            tx_drv_q <= 1'b0;
            transmit_enable_bit <= 1'b0;
            tx_st_q <= TX_IDLE;
          end else if (tx_eob) begin
            tx_tk_q <= 8'h00;
            tx_drv_q <= 1'b1;
            if (tx_st_q == TX_DATA && tx_bit_q == 4'h8) begin
              tx_st_q <= TX_ACK;
            end else begin
              tx_st_q <= TX_DATA;
              tx_bit_q <= tx_bit_q + 4'h1;
              tx_sh_q <= {tx_sh_q[7:0], 1'b0};
            end
          end
        end
        TX_ACK: begin
          if (tx_eob) begin
            tx_tk_q <= 8'h00;
            tx_st_q <= TX_IDLE;
            tx_irq <= 1'b1;
            tx_drv_q <= 1'b0;
            transmit_enable_bit <= 1'b0;
            if (tx_eom_q && !tx_ackerr) begin
              tx_end_flag <= 1'b1;
            end else if (!tx_eom_q && !fifo_valid) begin
              tx_underrun_flag <= 1'b1;
              tx_ack_pend_q <= tx_ackerr;
            end else if (tx_ackerr) begin
              tx_ack_error_flag <= 1'b1;
            end
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
      if (tx_load) begin
        tx_st_q <= TX_DATA;
        tx_sh_q <= fifo_data;
        tx_eom_q <= fifo_data[0];
        tx_bit_q <= 4'h0;
        tx_resp_q <= 1'b1;
        tx_start_flag <= 1'b1;
        tx_irq <= 1'b1;
        tx_drv_q <= 1'b1;
        transmit_enable_bit <= 1'b1;
      end
      if (!peripheral_enable) begin
        tx_st_q <= TX_IDLE;
        tx_drv_q <= 1'b0;
      end
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_oe <= 1'b0;
      line_out <= 1'b0;
    end else begin
      line_oe <= (rx_drv_q || tx_drv_q) && !soft_reset_bit;
      line_out <= 1'b0;
    end
  end
endmodule : cec_engine

/* verif/cec_engine_asserts.sv */
// cec_engine_asserts: port-level checks of the cec engine
// assumes a bind onto cec_engine, one clock domain
`timescale 1ns/100ps
module cec_engine_asserts #(
  parameter int TICK_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_oe,
  input wire logic soft_reset_bit,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  input wire logic rx_data_valid,
  input wire logic tx_irq,
  input wire logic tx_start_flag,
  input wire logic tx_end_flag,
  input wire logic arbitration_lost_flag,
  input wire logic tx_ack_error_flag,
  input wire logic tx_underrun_flag,
  input wire logic min_cycle_error_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_off;
    ##[0:2] !line_oe;
  endsequence
  a_start_irq: assert property ($rose(tx_start_flag) |-> tx_irq) else $error("start without irq");
  a_end_clears_en: assert property ($rose(tx_end_flag) |-> ##[0:1] !transmit_enable_bit)
    else $error("enable kept after end");
  a_arb_drive_off: assert property ($rose(arbitration_lost_flag) |-> !transmit_enable_bit ##0 s_off)
    else $error("drive kept after arbitration loss");
  a_ackerr_irq: assert property ($rose(tx_ack_error_flag) |-> tx_irq) else $error("ack error without irq");
  a_urun_first: assert property ($rose(tx_underrun_flag) |-> !tx_ack_error_flag)
    else $error("ack error before underrun");
  a_soft_clear: assert property (soft_reset_bit |=> !line_oe && !transmit_enable_bit && !tx_start_flag
    && !rx_data_valid) else $error("soft reset left state");
  a_rx_stop_low: assert property ($fell(receive_enable_bit) && !transmit_enable_bit |-> s_off)
    else $error("drive kept after receive off");
  a_min_err_low: assert property ($rose(min_cycle_error_flag) |-> ##[0:2] line_oe)
    else $error("no error low");
endmodule : cec_engine_asserts
bind cec_engine cec_engine_asserts #(.TICK_CYC(TICK_CYC)) cec_engine_asserts_inst (.*);

/* verif/cec_peer.sv */
// cec_peer: another device on the shared line: holds it low or sends frames
// assumes the bench resolves the open-drain wire from all enables
`timescale 1ns/100ps
module cec_peer #(
  parameter int TK = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hold_arm,
  input wire logic line_oe,
  output logic peer_oe,
  output logic init_oe
);
  initial init_oe = 1'b0;

  // one bit as initiator, times in ticks of the sampling base
  task automatic tx_bit(input int low_tk, input int prd_tk);
    init_oe <= 1'b1;
    repeat (low_tk * TK) @(posedge core_clk);
    init_oe <= 1'b0;
    repeat ((prd_tk - low_tk) * TK) @(posedge core_clk);
  endtask : tx_bit

  // start bit, 8 data bits msb first, eom, then an ack bit sent as one
  task automatic tx_frame(input logic [8:0] word);
    tx_bit(122, 148);
    for (int b = 8; b >= 0; b--) begin
      tx_bit(word[b] ? 20 : 50, 79);
    end
    tx_bit(20, 79);
  endtask : tx_frame

  // joins the engine's low and keeps the line low while armed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peer_oe <= 1'b0;
    end else begin
      peer_oe <= hold_arm && (peer_oe || line_oe);
    end
  end
endmodule : cec_peer

/* verif/cec_engine_tb.sv */
// cec_engine_tb: self-checking bench for the cec engine transmitter and receiver
// assumes cec_peer as the other device and a pulled-up line
`timescale 1ns/100ps
module cec_engine_tb;
  localparam int TK = 8;
  logic core_clk = 1'b0, rst = 1'b1, line_in, line_out, line_oe, peer_oe, init_oe, hold_arm = 1'b0;
  logic peripheral_enable = 1'b1, soft_reset_bit = 1'b0, receive_enable_bit = 1'b1, error_suspend_select = 1'b0;
  logic waveform_check_enable = 1'b1, ack_respond = 1'b0, rx_read = 1'b0, rx_status_clear = 1'b0;
  logic tx_enable_set = 1'b0, broadcast_select = 1'b0, tx_valid = 1'b0, tx_status_clear = 1'b0;
  logic rx_eom, rx_data_valid, rx_complete_flag, ack_collision_flag, min_cycle_error_flag, max_cycle_error_flag;
  logic rx_overrun_flag, waveform_error_flag, rx_irq, transmit_enable_bit, tx_ready, tx_start_flag, tx_end_flag;
  logic arbitration_lost_flag, tx_ack_error_flag, tx_underrun_flag, tx_irq;
  logic [3:0] suspend_timeout_value = 4'h0, bus_idle_wait_count = 4'h0;
  logic [1:0] start_rise_adjust = 2'h0, start_period_adjust = 2'h0, data_rise_adjust = 2'h0, data_period_adjust = 2'h0;
  logic [7:0] rx_data;
  logic [8:0] tx_data = 9'h000;
  int num_errors = 0, samples_checked = 0;
  // broadcast, eom, then expected ack error, underrun, end
  logic [4:0] rows [4] = '{5'h0c, 5'h19, 5'h12, 5'h06};
  assign line_in = !(line_oe || peer_oe || init_oe);
  cec_engine #(.TICK_CYC(TK)) cec_engine_inst (.*);
  cec_peer #(.TK(TK)) cec_peer_inst (.*);
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic send(input logic [8:0] word);
    tx_valid <= 1'b1;
    tx_data <= word;
    do @(posedge core_clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    tx_enable_set <= 1'b1;
    @(posedge core_clk);
    tx_enable_set <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int n = 0; n < 30000 && transmit_enable_bit !== 1'b0; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask : send
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("line_oe", 1'b0, line_oe);
    chk("tx_ready", 1'b1, tx_ready);
    for (int i = 0; i < 4; i++) begin
      broadcast_select <= rows[i][4];
      bus_idle_wait_count <= 4'(i);
      start_rise_adjust <= 2'(i);
      data_period_adjust <= 2'(i);
      tx_status_clear <= 1'b1;
      @(posedge core_clk);
      tx_status_clear <= 1'b0;
      send({8'ha5 ^ 8'(i), rows[i][3]});
      chk("tx_start_flag", 1'b1, tx_start_flag);
      chk("tx_ack_error_flag", rows[i][2], tx_ack_error_flag);
      chk("tx_underrun_flag", rows[i][1], tx_underrun_flag);
      chk("tx_end_flag", rows[i][0], tx_end_flag);
      $display("row %0d done", i);
    end
    hold_arm <= 1'b1;
    send(9'h0a3);
    chk("arbitration_lost_flag", 1'b1, arbitration_lost_flag);
    chk("transmit_enable_bit", 1'b0, transmit_enable_bit);
    hold_arm <= 1'b0;
    receive_enable_bit <= 1'b0;
    soft_reset_bit <= 1'b1;
    @(posedge core_clk);
    soft_reset_bit <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("arbitration_lost_flag", 1'b0, arbitration_lost_flag);
    chk("line_oe", 1'b0, line_oe);
    $display("arbitration and soft reset done");
    receive_enable_bit <= 1'b1;
    ack_respond <= 1'b1;
    @(posedge core_clk);
    cec_peer_inst.tx_frame(9'h12d);
    chk("rx_byte", 9'h12d, {rx_data, rx_eom});
    chk("rx_data_valid", 1'b1, rx_data_valid);
    chk("rx_complete_flag", 1'b1, rx_complete_flag);
    chk("ack_collision_flag", 1'b0, ack_collision_flag);
    chk("waveform_error_flag", 1'b0, waveform_error_flag);
    cec_peer_inst.tx_frame(9'h079);
    chk("rx_overrun_flag", 1'b1, rx_overrun_flag);
    chk("rx_byte", 9'h12d, {rx_data, rx_eom});
    chk("min_cycle_error_flag", 1'b0, min_cycle_error_flag);
    $display("receive and overrun done");
    cec_peer_inst.tx_bit(122, 148);
    cec_peer_inst.tx_bit(20, 40);
    cec_peer_inst.tx_bit(20, 20);
    chk("min_cycle_error_flag", 1'b1, min_cycle_error_flag);
    chk("line_oe", 1'b1, line_oe);
    receive_enable_bit <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("line_oe", 1'b0, line_oe);
    $display("minimum cycle error and receive stop done");
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : cec_engine_tb
